// file: uio_pkg.sv
// Package: register map, field layouts, reset values and timing for the user I/O block
`default_nettype none
package uio_pkg;
   // ------------------------------------------------------------
   // Register byte offsets
   // ------------------------------------------------------------
   localparam logic [7:0] OFF_PIN_COUNT  = 8'h00;
   localparam logic [7:0] OFF_DIR        = 8'h04;
   localparam logic [7:0] OFF_DIR_MASK   = 8'h08;
   localparam logic [7:0] OFF_LEVEL      = 8'h0C;
   localparam logic [7:0] OFF_LEVEL_MASK = 8'h10;
   localparam logic [7:0] OFF_SS_DELAY   = 8'h14;
   localparam logic [7:0] OFF_SS_WIDTH   = 8'h18;
   localparam logic [7:0] OFF_SS_ENABLE  = 8'h1C;
   localparam logic [7:0] OFF_CS_PERIOD  = 8'h20;
   localparam logic [7:0] OFF_CS_ENABLE  = 8'h24;
   // ------------------------------------------------------------
   // Fields, reset values, limits and timing
   // ------------------------------------------------------------
   localparam int          PIN_COUNT     = 4;
   localparam int          ENABLE_BIT    = 0;
   localparam logic [31:0] RST_DELAY     = 32'h0000_0005;
   localparam logic [31:0] RST_WIDTH     = 32'h0000_0001;
   localparam logic [31:0] RST_PERIOD    = 32'h0000_0032;
   localparam logic [31:0] MIN_DELAY_US  = 32'h0000_0005;
   localparam logic [31:0] MIN_WIDTH_US  = 32'h0000_0001;
   localparam logic [31:0] MIN_PERIOD_US = 32'h0000_0032;
   localparam int          CLK_MHZ       = 125;
   localparam int          US_NS         = 1000;
   localparam int          CLK_PERIOD_NS = 8;
   localparam int          CYC_PER_US    = US_NS / CLK_PERIOD_NS;
   localparam logic [1:0]  HTRANS_NONSEQ = 2'h2;
   // Bundle of strobe settings passed to the generator
   typedef struct packed {
      logic [31:0] delay_us;
      logic [31:0] width_us;
      logic        single_en;
      logic [31:0] period_us;
      logic        cont_en;
   } uio_strobe_cfg_t;
   typedef enum logic [1:0] {
      SS_IDLE  = 2'b00,
      SS_DELAY = 2'b01,
      SS_PULSE = 2'b10
   } uio_ss_state_t;
endpackage
`default_nettype wire

// file: uio_strobe_gen.sv
// Strobe generator: delayed single pulse and continuous periodic strobe
`default_nettype none
module uio_strobe_gen (
   input  wire logic                     mclk,
   input  wire logic                     rst_n,
   input  wire uio_pkg::uio_strobe_cfg_t cfg,
   input  wire logic                     acq_start,
   output logic                          single_out,
   output logic                          cont_out
);
   // ------------------------------------------------------------
   // Microsecond timebase
   // ------------------------------------------------------------
   logic [7:0]  pre_reg;
   logic        us_tick;
   assign us_tick = (pre_reg == 8'(uio_pkg::CYC_PER_US - 1));
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) pre_reg <= 8'h00;
      else if (us_tick) pre_reg <= 8'h00;
      else pre_reg <= pre_reg + 8'h01;
   end
   // ------------------------------------------------------------
   // Single pulse after delay
   // ------------------------------------------------------------
   uio_pkg::uio_ss_state_t ss_reg;
   logic [31:0] ss_cnt_reg;
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         ss_reg     <= uio_pkg::SS_IDLE;
         ss_cnt_reg <= 32'h0000_0000;
         single_out <= 1'b0;
      end else begin
         case (ss_reg)
            uio_pkg::SS_IDLE: begin
               single_out <= 1'b0;
               if (cfg.single_en && acq_start) begin
                  ss_reg     <= uio_pkg::SS_DELAY;
                  ss_cnt_reg <= 32'h0000_0000;
               end
            end
            uio_pkg::SS_DELAY: begin
               if (!cfg.single_en) ss_reg <= uio_pkg::SS_IDLE;
               else if (us_tick) begin
                  if (ss_cnt_reg + 32'h1 >= cfg.delay_us) begin
                     ss_reg     <= uio_pkg::SS_PULSE;
                     ss_cnt_reg <= 32'h0000_0000;
                     single_out <= 1'b1;
                  end else ss_cnt_reg <= ss_cnt_reg + 32'h1;
               end
            end
            uio_pkg::SS_PULSE: begin
               if (us_tick) begin
                  if (ss_cnt_reg + 32'h1 >= cfg.width_us) begin
                     ss_reg     <= uio_pkg::SS_IDLE;
                     single_out <= 1'b0;
                  end else ss_cnt_reg <= ss_cnt_reg + 32'h1;
               end
            end
            default: begin
               ss_reg     <= uio_pkg::SS_IDLE;
               single_out <= 1'b0;
            end
         endcase
      end
   end
   // ------------------------------------------------------------
   // Continuous strobe: one microsecond pulse each period
   // ------------------------------------------------------------
   logic [31:0] cs_cnt_reg;
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         cs_cnt_reg <= 32'h0000_0000;
         cont_out   <= 1'b0;
      end else if (!cfg.cont_en) begin
         cs_cnt_reg <= 32'h0000_0000;
         cont_out   <= 1'b0;
      end else if (us_tick) begin
         if (cs_cnt_reg + 32'h1 >= cfg.period_us) begin
            cs_cnt_reg <= 32'h0000_0000;
            cont_out   <= 1'b1;
         end else begin
            cs_cnt_reg <= cs_cnt_reg + 32'h1;
            cont_out   <= 1'b0;
         end
      end
   end
endmodule
`default_nettype wire

// file: uio_top.sv
// Top: AHB-Lite register slave, user pins and strobe outputs
// Summary of operation
// - Vector bits 0..3 map to pins 1..4
// - Pin count query returns four
// - Direction read: one where pin drives
// - Direction write: vector under mask
// - Level read: inputs sampled, outputs programmed
// - Level write: vector under mask
// - Level write ignores input pins
// - Single strobe delay, microseconds, host min five
// - Single strobe width, microseconds, host min one
// - Single strobe enable byte, 0 off 1 on
// - Continuous period, microseconds, host min fifty
// - Continuous enable byte, 0 stops 1 starts
`default_nettype none
module uio_top #(
   parameter int NPINS = uio_pkg::PIN_COUNT
) (
   input  wire logic             mclk,
   input  wire logic             rst_n,
   input  wire logic             hsel,
   input  wire logic [31:0]      haddr,
   input  wire logic [1:0]       htrans,
   input  wire logic             hwrite,
   input  wire logic [2:0]       hsize,
   input  wire logic [31:0]      hwdata,
   input  wire logic             hready,
   output logic [31:0]           hrdata,
   output logic                  hreadyout,
   output logic                  hresp,
   input  wire logic [NPINS-1:0] pin_in,
   output logic [NPINS-1:0]      pin_out,
   output logic [NPINS-1:0]      pin_oe,
   input  wire logic             acq_start,
   output logic                  strobe_single,
   output logic                  strobe_cont
);
   // ------------------------------------------------------------
   // Bus address phase capture
   // ------------------------------------------------------------
   logic       wr_pend_reg;
   logic [7:0] waddr_reg;
   logic       take;
   assign take = hsel && hready && (htrans == uio_pkg::HTRANS_NONSEQ);
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         wr_pend_reg <= 1'b0;
         waddr_reg   <= 8'h00;
      end else begin
         wr_pend_reg <= take && hwrite;
         if (take) waddr_reg <= haddr[7:0];
      end
   end
   // Zero wait states, always OKAY
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         hreadyout <= 1'b1;
         hresp     <= 1'b0;
      end else begin
         hreadyout <= 1'b1;
         hresp     <= 1'b0;
      end
   end
   // ------------------------------------------------------------
   // Configuration registers
   // ------------------------------------------------------------
   logic [NPINS-1:0] dir_reg;
   logic [NPINS-1:0] lvl_reg;
   logic [31:0]      dir_mask_reg;
   logic [31:0]      lvl_mask_reg;
   logic [NPINS-1:0] pin_in_reg;
   uio_pkg::uio_strobe_cfg_t cfg_reg;
   function automatic logic [NPINS-1:0] masked(input logic [NPINS-1:0] old_v,
                                                input logic [31:0] vec,
                                                input logic [31:0] msk);
      masked = (old_v & ~msk[NPINS-1:0]) | (vec[NPINS-1:0] & msk[NPINS-1:0]);
   endfunction
   function automatic logic wr_hit(input logic [7:0] off);
      wr_hit = wr_pend_reg && (waddr_reg == off);
   endfunction
   // Mask is written first; the vector write applies it in one step
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         dir_mask_reg <= 32'h0000_0000;
         lvl_mask_reg <= 32'h0000_0000;
      end else begin
         if (wr_hit(uio_pkg::OFF_DIR_MASK)) dir_mask_reg <= hwdata;
         if (wr_hit(uio_pkg::OFF_LEVEL_MASK)) lvl_mask_reg <= hwdata;
      end
   end
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) dir_reg <= '0;
      else if (wr_hit(uio_pkg::OFF_DIR))
         dir_reg <= masked(dir_reg, hwdata, dir_mask_reg);
   end
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) lvl_reg <= '0;
      else if (wr_hit(uio_pkg::OFF_LEVEL))
         lvl_reg <= masked(lvl_reg, hwdata, lvl_mask_reg & 32'(dir_reg));
   end
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) cfg_reg <= '{uio_pkg::RST_DELAY, uio_pkg::RST_WIDTH, 1'b0,
                               uio_pkg::RST_PERIOD, 1'b0};
      else begin
         if (wr_hit(uio_pkg::OFF_SS_DELAY)) cfg_reg.delay_us <= hwdata;
         if (wr_hit(uio_pkg::OFF_SS_WIDTH)) cfg_reg.width_us <= hwdata;
         if (wr_hit(uio_pkg::OFF_SS_ENABLE))
            cfg_reg.single_en <= hwdata[uio_pkg::ENABLE_BIT];
         if (wr_hit(uio_pkg::OFF_CS_PERIOD)) cfg_reg.period_us <= hwdata;
         if (wr_hit(uio_pkg::OFF_CS_ENABLE))
            cfg_reg.cont_en <= hwdata[uio_pkg::ENABLE_BIT];
      end
   end
   // ------------------------------------------------------------
   // Pins
   // ------------------------------------------------------------
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         pin_out    <= '0;
         pin_oe     <= '0;
         pin_in_reg <= '0;
      end else begin
         pin_out    <= lvl_reg & dir_reg;
         pin_oe     <= dir_reg;
         pin_in_reg <= pin_in;
      end
   end
   // ------------------------------------------------------------
   // Read data, registered in the address phase
   // ------------------------------------------------------------
   logic [31:0] rd_next;
   always_comb begin
      rd_next = 32'h0000_0000;
      case (haddr[7:0])
         uio_pkg::OFF_PIN_COUNT:  rd_next = 32'(NPINS);
         uio_pkg::OFF_DIR:        rd_next = 32'(dir_reg);
         uio_pkg::OFF_DIR_MASK:   rd_next = dir_mask_reg;
         uio_pkg::OFF_LEVEL:
            rd_next = 32'((dir_reg & lvl_reg) | (~dir_reg & pin_in_reg));
         uio_pkg::OFF_LEVEL_MASK: rd_next = lvl_mask_reg;
         uio_pkg::OFF_SS_DELAY:   rd_next = cfg_reg.delay_us;
         uio_pkg::OFF_SS_WIDTH:   rd_next = cfg_reg.width_us;
         uio_pkg::OFF_SS_ENABLE:  rd_next = 32'(cfg_reg.single_en);
         uio_pkg::OFF_CS_PERIOD:  rd_next = cfg_reg.period_us;
         uio_pkg::OFF_CS_ENABLE:  rd_next = 32'(cfg_reg.cont_en);
         default:                 rd_next = 32'h0000_0000;
      endcase
   end
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) hrdata <= 32'h0000_0000;
      else if (take && !hwrite) hrdata <= rd_next;
   end
   // ------------------------------------------------------------
   // Strobe generator
   // ------------------------------------------------------------
   uio_strobe_gen u_strobe (
      .mclk       (mclk),
      .rst_n      (rst_n),
      .cfg        (cfg_reg),
      .acq_start  (acq_start),
      .single_out (strobe_single),
      .cont_out   (strobe_cont)
   );
   // ------------------------------------------------------------
   // Checks
   // ------------------------------------------------------------
   // Write hits are spelled out: a function body inside a property reads
   // current, not sampled, values and would miss the write edge
   a_oe_follows_dir: assert property (@(posedge mclk) disable iff (!rst_n)
      1'b1 |=> pin_oe == $past(dir_reg)) else $error("pin_oe not following direction");
   a_input_no_drive: assert property (@(posedge mclk) disable iff (!rst_n)
      1'b1 |=> ((pin_out & ~pin_oe) == '0)) else $error("input pin driven high");
   a_dir_mask_keep: assert property (@(posedge mclk) disable iff (!rst_n)
      wr_pend_reg && waddr_reg == uio_pkg::OFF_DIR
      |=> ((dir_reg ^ $past(dir_reg)) & ~$past(dir_mask_reg[NPINS-1:0])) == '0)
      else $error("direction changed outside mask");
   a_dir_write_set: assert property (@(posedge mclk) disable iff (!rst_n)
      wr_pend_reg && waddr_reg == uio_pkg::OFF_DIR
      |=> ((dir_reg ^ $past(hwdata[NPINS-1:0])) & $past(dir_mask_reg[NPINS-1:0])) == '0)
      else $error("direction write lost");
   a_lvl_input_keep: assert property (@(posedge mclk) disable iff (!rst_n)
      wr_pend_reg && waddr_reg == uio_pkg::OFF_LEVEL
      |=> ((lvl_reg ^ $past(lvl_reg)) & ~$past(dir_reg)) == '0)
      else $error("level of input pin changed");
   a_lvl_write_set: assert property (@(posedge mclk) disable iff (!rst_n)
      wr_pend_reg && waddr_reg == uio_pkg::OFF_LEVEL
      |=> ((lvl_reg ^ $past(hwdata[NPINS-1:0]))
         & $past(dir_reg & lvl_mask_reg[NPINS-1:0])) == '0)
      else $error("level write lost");
   a_count_read: assert property (@(posedge mclk) disable iff (!rst_n)
      take && !hwrite && haddr[7:0] == uio_pkg::OFF_PIN_COUNT |=> hrdata == 32'(NPINS))
      else $error("pin count wrong");
   a_single_off: assert property (@(posedge mclk) disable iff (!rst_n)
      !cfg_reg.single_en && !strobe_single |=> !strobe_single)
      else $error("single strobe while disabled");
   a_cont_off: assert property (@(posedge mclk) disable iff (!rst_n)
      !cfg_reg.cont_en |=> !strobe_cont) else $error("continuous strobe while disabled");
endmodule
`default_nettype wire

// file: uio_pin_model.sv
// Pin-side model: the outside world seen by the four user pins
`default_nettype none
module uio_pin_model (
   input  wire logic [3:0] pin_out,
   input  wire logic [3:0] pin_oe,
   input  wire logic [3:0] ext_lvl,
   output logic      [3:0] pin_in
);
   timeunit 1ns;
   timeprecision 1ps;
   // ---------------------------------------------
   // Wire level
   // ---------------------------------------------
   // Driven pins echo the block; released pins follow the outside driver, never a stale value
   assign pin_in = (pin_oe & pin_out) | (~pin_oe & ext_lvl);
endmodule
`default_nettype wire

// file: tb_user_io_and_strobe_control.sv
// Testbench: bus access, pin control and strobe timing of the user I/O block
`default_nettype none
module tb_user_io_and_strobe_control;
   timeunit 1ns;
   timeprecision 1ps;
   localparam int C = uio_pkg::CYC_PER_US;
   // ---------------------------------------------
   // Signals
   // ---------------------------------------------
   logic        mclk, rst_n, hsel, hwrite, hreadyout, hresp, acq_start;
   logic        strobe_single, strobe_cont;
   logic [31:0] haddr, hwdata, hrdata;
   logic [1:0]  htrans;
   logic [2:0]  hsize;
   logic [3:0]  pin_in, pin_out, pin_oe, ext_lvl;
   int          n_mismatch, compares;
   // ---------------------------------------------
   // Instances
   // ---------------------------------------------
   // One slave only, so its ready is the bus ready
   uio_top #(.NPINS(4)) dut_u (.mclk(mclk), .rst_n(rst_n), .hsel(hsel), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
      .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .pin_in(pin_in),
      .pin_out(pin_out), .pin_oe(pin_oe), .acq_start(acq_start),
      .strobe_single(strobe_single), .strobe_cont(strobe_cont));
   uio_pin_model pins_u (.pin_out(pin_out), .pin_oe(pin_oe), .ext_lvl(ext_lvl), .pin_in(pin_in));
   initial begin
      mclk = 1'b0;
      forever #4 mclk = ~mclk;
   end
   // ---------------------------------------------
   // Shared tasks
   // ---------------------------------------------
   task automatic wrap_up;
      if (n_mismatch == 0 && compares > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask
   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      compares++;
      if (g !== e) begin
         n_mismatch++;
         $display("BAD %s expected %h seen %h", nm, e, g);
      end
   endtask
   task automatic chk_rng(input string nm, input int lo, input int hi, input int n);
      compares++;
      if (n < lo || n > hi) begin
         n_mismatch++;
         $display("BAD %s expected %0d..%0d seen %0d", nm, lo, hi, n);
      end
   endtask
   task automatic wait_rdy;
      int n;
      n = 0;
      do begin
         @(posedge mclk);
         n++;
         if (n > 64) begin
            n_mismatch++;
            wrap_up();
         end
      end while (hreadyout !== 1'b1);
   endtask
   task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] r);
      hsel   <= 1'b1;
      haddr  <= {24'h0, a};
      htrans <= uio_pkg::HTRANS_NONSEQ;
      hwrite <= w;
      wait_rdy();
      hsel   <= 1'b0;
      htrans <= 2'h0;
      hwdata <= d;
      wait_rdy();
      r = hrdata;
      chk("hresp", 32'h0, {31'h0, hresp});
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] r;
      bus(1'b1, a, d, r);
   endtask
   task automatic rd_chk(input string nm, input logic [7:0] a, input logic [31:0] e);
      logic [31:0] r;
      bus(1'b0, a, 32'h0, r);
      chk(nm, e, r);
   endtask
   // Pin outputs follow one edge after the register, so two edges is enough
   task automatic settle;
      repeat (2) @(posedge mclk);
   endtask
   task automatic cnt_until(input bit cont, input logic lvl, input int lim, output int n);
      n = 0;
      while ((cont ? strobe_cont : strobe_single) !== lvl && n < lim) begin
         @(posedge mclk);
         n++;
      end
   endtask
   task automatic acq_pulse;
      acq_start <= 1'b1;
      @(posedge mclk);
      acq_start <= 1'b0;
   endtask
   // ---------------------------------------------
   // Scenarios
   // ---------------------------------------------
   task automatic t_reset;
      chk("pin_oe_rst", 32'h0, {28'h0, pin_oe});
      rd_chk("pin_count", uio_pkg::OFF_PIN_COUNT, 32'h4);
      wr(uio_pkg::OFF_PIN_COUNT, 32'hFF);
      rd_chk("pin_count_ro", uio_pkg::OFF_PIN_COUNT, 32'h4);
      rd_chk("dir_rst", uio_pkg::OFF_DIR, 32'h0);
      rd_chk("delay_rst", uio_pkg::OFF_SS_DELAY, uio_pkg::RST_DELAY);
      rd_chk("width_rst", uio_pkg::OFF_SS_WIDTH, uio_pkg::RST_WIDTH);
      rd_chk("ss_en_rst", uio_pkg::OFF_SS_ENABLE, 32'h0);
      rd_chk("period_rst", uio_pkg::OFF_CS_PERIOD, uio_pkg::RST_PERIOD);
      rd_chk("cs_en_rst", uio_pkg::OFF_CS_ENABLE, 32'h0);
      wr(8'h28, 32'hFFFF_FFFF);
      rd_chk("unmapped", 8'h28, 32'h0);
   endtask
   task automatic t_dir;
      wr(uio_pkg::OFF_DIR_MASK, 32'h3);
      wr(uio_pkg::OFF_DIR, 32'hF);
      rd_chk("dir_a", uio_pkg::OFF_DIR, 32'h3);
      settle();
      chk("pin_oe_a", 32'h3, {28'h0, pin_oe});
      wr(uio_pkg::OFF_DIR_MASK, 32'hC);
      wr(uio_pkg::OFF_DIR, 32'h9);
      rd_chk("dir_b", uio_pkg::OFF_DIR, 32'hB);
      settle();
      chk("pin_oe_b", 32'hB, {28'h0, pin_oe});
   endtask
   // Pin 3 is an input during the level writes, so it must drive low once it is an output
   task automatic t_level;
      ext_lvl <= 4'h4;
      wr(uio_pkg::OFF_LEVEL_MASK, 32'hF);
      wr(uio_pkg::OFF_LEVEL, 32'hF);
      settle();
      chk("pin_out_a", 32'hB, {28'h0, pin_out});
      rd_chk("level_a", uio_pkg::OFF_LEVEL, 32'hF);
      ext_lvl <= 4'h0;
      settle();
      rd_chk("level_b", uio_pkg::OFF_LEVEL, 32'hB);
      wr(uio_pkg::OFF_LEVEL_MASK, 32'h2);
      wr(uio_pkg::OFF_LEVEL, 32'h0);
      settle();
      chk("pin_out_b", 32'h9, {28'h0, pin_out});
      rd_chk("level_c", uio_pkg::OFF_LEVEL, 32'h9);
      wr(uio_pkg::OFF_DIR_MASK, 32'h4);
      wr(uio_pkg::OFF_DIR, 32'h4);
      settle();
      chk("pin_oe_c", 32'hF, {28'h0, pin_oe});
      chk("pin_out_c", 32'h9, {28'h0, pin_out});
      rd_chk("level_d", uio_pkg::OFF_LEVEL, 32'h9);
   endtask
   // The microsecond tick runs free, so edges may land one microsecond either way
   task automatic t_single;
      int n;
      wr(uio_pkg::OFF_SS_DELAY, uio_pkg::MIN_DELAY_US);
      wr(uio_pkg::OFF_SS_WIDTH, 32'h3);
      wr(uio_pkg::OFF_SS_ENABLE, 32'h1);
      acq_pulse();
      cnt_until(1'b0, 1'b1, 2000, n);
      chk_rng("ss_delay", 4 * C, 6 * C, n);
      cnt_until(1'b0, 1'b0, 1000, n);
      chk_rng("ss_width", 2 * C, 4 * C, n);
      acq_pulse();
      cnt_until(1'b0, 1'b1, 2000, n);
      chk_rng("ss_again", 4 * C, 6 * C, n);
      cnt_until(1'b0, 1'b0, 1000, n);
      chk_rng("ss_width_b", 2 * C, 4 * C, n);
      wr(uio_pkg::OFF_SS_ENABLE, 32'h0);
      acq_pulse();
      cnt_until(1'b0, 1'b1, 1000, n);
      chk_rng("ss_off", 1000, 1000, n);
   endtask
   task automatic t_cont;
      int n;
      wr(uio_pkg::OFF_CS_PERIOD, uio_pkg::MIN_PERIOD_US);
      wr(uio_pkg::OFF_CS_ENABLE, 32'h1);
      cnt_until(1'b1, 1'b1, 7000, n);
      chk_rng("cs_start", 0, 6999, n);
      cnt_until(1'b1, 1'b0, 300, n);
      chk_rng("cs_high", C - 1, C + 1, n);
      cnt_until(1'b1, 1'b1, 7000, n);
      chk_rng("cs_gap", 49 * C - 1, 49 * C + 1, n);
      wr(uio_pkg::OFF_CS_ENABLE, 32'h0);
      settle();
      chk("cs_drop", 32'h0, {31'h0, strobe_cont});
      cnt_until(1'b1, 1'b1, 7000, n);
      chk_rng("cs_stopped", 7000, 7000, n);
   endtask
   // ---------------------------------------------
   // Main sequence
   // ---------------------------------------------
   initial begin
      rst_n = 1'b0;
      hsel = 1'b0;
      haddr = 32'h0;
      htrans = 2'h0;
      hwrite = 1'b0;
      hsize = 3'h2;
      hwdata = 32'h0;
      acq_start = 1'b0;
      ext_lvl = 4'h5;
      n_mismatch = 0;
      compares = 0;
      repeat (12) @(posedge mclk);
      rst_n <= 1'b1;
      @(posedge mclk);
      t_reset();
      t_dir();
      t_level();
      t_single();
      t_cont();
      wrap_up();
   end
endmodule
`default_nettype wire
